// >>> core/port_cfg_pkg.sv
// Constants, types and helpers shared by the port configuration loader
//
// Functional notes
// R1: Ports 2-5 words at image 64h,66h,68h,6Ah
// R2: Word bit 0 to C0h bit 24
// R3: Word bit 1 to D0h bit 28
// R4: Word bit 2 to 40h bit 21
// R5: Word bit 3 to 144h bit 4
// R6: Word bits 6:4 to CCh bits 26:24
// R7: Word bits 15:9 to 154h bits 7:1
// R8: Fields apply only after all words load
`default_nettype none

package port_cfg_pkg;

  localparam int NUM_PORTS = 4;
  localparam int PNUM_W = 3;
  localparam int TCMAP_W = 7;

  // Image word addresses of the per-port words
  localparam logic [7:0] IMG_PORT2_WORD = 8'h64;
  localparam logic [7:0] IMG_WORD_STEP = 8'h02;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_PORT2_WORD = 12'h064;
  localparam logic [11:0] IDX_PORT3_WORD = 12'h066;
  localparam logic [11:0] IDX_PORT4_WORD = 12'h068;
  localparam logic [11:0] IDX_PORT5_WORD = 12'h06A;
  localparam logic [11:0] IDX_CTRL = 12'h070;
  localparam logic [11:0] IDX_STATUS = 12'h071;

  // Control and status bits
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // Built-in value of a word before loading
  localparam logic [15:0] INIT_WORD_DEFAULT = 16'h0000;

  // Source bit positions inside an initialization word
  localparam int SRC_SLOT_BIT = 0;
  localparam int SRC_CLK_BIT = 1;
  localparam int SRC_DSI_BIT = 2;
  localparam int SRC_LPVC_BIT = 3;
  localparam int SRC_PNUM_LSB = 4;
  localparam int SRC_TCMAP_LSB = 9;

  // Destination configuration offsets and bit positions
  localparam logic [11:0] CFG_SLOT_OFS = 12'h0C0;
  localparam int DST_SLOT_BIT = 24;
  localparam logic [11:0] CFG_CLK_OFS = 12'h0D0;
  localparam int DST_CLK_BIT = 28;
  localparam logic [11:0] CFG_DSI_OFS = 12'h040;
  localparam int DST_DSI_BIT = 21;
  localparam logic [11:0] CFG_LPVC_OFS = 12'h144;
  localparam int DST_LPVC_BIT = 4;
  localparam logic [11:0] CFG_PNUM_OFS = 12'h0CC;
  localparam int DST_PNUM_LSB = 24;
  localparam logic [11:0] CFG_TCMAP_OFS = 12'h154;
  localparam int DST_TCMAP_LSB = 1;

  // Loader states
  typedef enum logic [1:0] {
    LD_IDLE,
    LD_REQ,
    LD_DONE
  } load_state_t;

  // Byte address of a register index
  function automatic logic [11:0] regByteAddr(input logic [11:0] idx);
    regByteAddr = {idx[9:0], 2'b00};
  endfunction : regByteAddr

  // Image word address of a port slot
  function automatic logic [7:0] imgWordAddr(input logic [1:0] slot);
    imgWordAddr = IMG_PORT2_WORD + IMG_WORD_STEP * {6'h00, slot};
  endfunction : imgWordAddr

  // Half-word merge under APB byte strobes
  function automatic logic [15:0] mergeHalf(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [1:0] strb);
    mergeHalf = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction : mergeHalf

endpackage : port_cfg_pkg

`default_nettype wire

// >>> core/init_word_unpack.sv
// Unpacks one initialization word into its configuration fields
`default_nettype none

module init_word_unpack (
  // Source word
  input wire logic [15:0] initWord,
  // Extracted fields
  output logic slotImpl,
  output logic slotClk,
  output logic dsiReq,
  output logic lpvcOne,
  output logic [2:0] portNum,
  output logic [6:0] tcVcMap
);

  // R2: slot implemented flag
  assign slotImpl = initWord[port_cfg_pkg::SRC_SLOT_BIT];
  // R3: connector clock flag
  assign slotClk = initWord[port_cfg_pkg::SRC_CLK_BIT];
  // R4: device specific init flag
  assign dsiReq = initWord[port_cfg_pkg::SRC_DSI_BIT];
  // R5: low priority channel count
  assign lpvcOne = initWord[port_cfg_pkg::SRC_LPVC_BIT];
  // R6: logical port number
  assign portNum = initWord[port_cfg_pkg::SRC_PNUM_LSB +: port_cfg_pkg::PNUM_W];
  // R7: traffic class to VC0 map
  assign tcVcMap = initWord[port_cfg_pkg::SRC_TCMAP_LSB +: port_cfg_pkg::TCMAP_W];

endmodule : init_word_unpack

`default_nettype wire

// >>> core/port_config_word_loader.sv
// Loads per-port configuration words for ports 2-5 from the image and applies them
//
// The implementer's own choice: the APB slave port.
`default_nettype none

module port_config_word_loader (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration image memory
  output logic imgRd,
  output logic [7:0] imgAddr,
  input wire logic [15:0] imgData,
  input wire logic imgValid,
  // Applied per-port fields, port 2 in the lowest slice
  output logic [3:0] slotImpl,
  output logic [3:0] slotClk,
  output logic [3:0] dsiReq,
  output logic [3:0] lpvcOne,
  output logic [11:0] portNum,
  output logic [27:0] tcVcMap,
  output logic loadDone
);

  port_cfg_pkg::load_state_t state_q;
  logic [1:0] slot_q;
  logic imgRd_q;
  logic [7:0] imgAddr_q;
  logic done_q;
  logic [15:0] word_q [port_cfg_pkg::NUM_PORTS];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [3:0] slotImpl_q;
  logic [3:0] slotClk_q;
  logic [3:0] dsiReq_q;
  logic [3:0] lpvcOne_q;
  logic [11:0] portNum_q;
  logic [27:0] tcVcMap_q;

  // APB phase decode
  wire setupPhase = psel & ~penable;
  wire commit = psel & penable & pready_q;
  wire wrCommit = commit & pwrite;
  wire hitCtrl = (paddr == port_cfg_pkg::regByteAddr(port_cfg_pkg::IDX_CTRL));
  wire hitStatus = (paddr == port_cfg_pkg::regByteAddr(port_cfg_pkg::IDX_STATUS));
  wire [3:0] hitWord;
  wire reloadReq = wrCommit & hitCtrl & pstrb[0] & pwdata[port_cfg_pkg::CTRL_RELOAD_BIT];
  wire wordTaken = imgRd_q & imgValid;
  wire busy = ~done_q;

  // Word register hits, one per port
  assign hitWord[0] = (paddr == port_cfg_pkg::regByteAddr(port_cfg_pkg::IDX_PORT2_WORD));
  assign hitWord[1] = (paddr == port_cfg_pkg::regByteAddr(port_cfg_pkg::IDX_PORT3_WORD));
  assign hitWord[2] = (paddr == port_cfg_pkg::regByteAddr(port_cfg_pkg::IDX_PORT4_WORD));
  assign hitWord[3] = (paddr == port_cfg_pkg::regByteAddr(port_cfg_pkg::IDX_PORT5_WORD));
  wire mapped = (|hitWord) | hitCtrl | hitStatus;

  // Read data selection
  wire [15:0] wordSel = hitWord[0] ? word_q[0] :
                        hitWord[1] ? word_q[1] :
                        hitWord[2] ? word_q[2] :
                        hitWord[3] ? word_q[3] : 16'h0000;
  wire [31:0] statusWord = {30'h00000000, busy, done_q};
  wire [31:0] rdMux = hitStatus ? statusWord :
                      (|hitWord) ? {16'h0000, wordSel} : 32'h00000000;

  // APB answer: data and ready set up one cycle ahead of the access phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setupPhase;
      prdata_q <= (setupPhase & ~pwrite) ? rdMux : 32'h00000000;
      pslverr_q <= setupPhase & ~mapped;
    end
  end

  // R1: image fetch sequencer, one word per port in port order
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= port_cfg_pkg::LD_IDLE;
      slot_q <= 2'b00;
      imgRd_q <= 1'b0;
      imgAddr_q <= 8'h00;
      done_q <= 1'b0;
    end else if (reloadReq) begin
      state_q <= port_cfg_pkg::LD_IDLE;
      slot_q <= 2'b00;
      imgRd_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        port_cfg_pkg::LD_IDLE: begin
          state_q <= port_cfg_pkg::LD_REQ;
          imgRd_q <= 1'b1;
          imgAddr_q <= port_cfg_pkg::imgWordAddr(slot_q);
        end
        port_cfg_pkg::LD_REQ: begin
          if (imgValid) begin
            imgRd_q <= 1'b0;
            if (slot_q == 2'b11) begin
              state_q <= port_cfg_pkg::LD_DONE;
              done_q <= 1'b1;
            end else begin
              state_q <= port_cfg_pkg::LD_IDLE;
              slot_q <= slot_q + 2'b01;
            end
          end
        end
        default: begin
          imgRd_q <= 1'b0;
        end
      endcase
    end
  end

  // Word store; a fetched word wins over a same-cycle software write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < port_cfg_pkg::NUM_PORTS; p++) begin
        word_q[p] <= port_cfg_pkg::INIT_WORD_DEFAULT;
      end
    end else begin
      for (int p = 0; p < port_cfg_pkg::NUM_PORTS; p++) begin
        if (wordTaken && slot_q == p[1:0]) begin
          word_q[p] <= imgData;
        end else if (wrCommit && hitWord[p]) begin
          word_q[p] <= port_cfg_pkg::mergeHalf(word_q[p], pwdata[15:0], pstrb[1:0]);
        end
      end
    end
  end

  // Per-port unpack of the effective word
  wire [3:0] slotImplD;
  wire [3:0] slotClkD;
  wire [3:0] dsiReqD;
  wire [3:0] lpvcOneD;
  wire [11:0] portNumD;
  wire [27:0] tcVcMapD;
  genvar g;
  generate
    for (g = 0; g < port_cfg_pkg::NUM_PORTS; g++) begin : gPort
      // R8: defaults stand until every word is loaded
      wire [15:0] effWord = done_q ? word_q[g] : port_cfg_pkg::INIT_WORD_DEFAULT;
      init_word_unpack uUnpack (
        .initWord(effWord),
        .slotImpl(slotImplD[g]),
        .slotClk(slotClkD[g]),
        .dsiReq(dsiReqD[g]),
        .lpvcOne(lpvcOneD[g]),
        .portNum(portNumD[g*3 +: 3]),
        .tcVcMap(tcVcMapD[g*7 +: 7])
      );
    end
  endgenerate

  // Registered field outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slotImpl_q <= 4'h0;
      slotClk_q <= 4'h0;
      dsiReq_q <= 4'h0;
      lpvcOne_q <= 4'h0;
      portNum_q <= 12'h000;
      tcVcMap_q <= 28'h0000000;
    end else begin
      slotImpl_q <= slotImplD;
      slotClk_q <= slotClkD;
      dsiReq_q <= dsiReqD;
      lpvcOne_q <= lpvcOneD;
      portNum_q <= portNumD;
      tcVcMap_q <= tcVcMapD;
    end
  end

  // Output drive
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign imgRd = imgRd_q;
  assign imgAddr = imgAddr_q;
  assign slotImpl = slotImpl_q;
  assign slotClk = slotClk_q;
  assign dsiReq = dsiReq_q;
  assign lpvcOne = lpvcOne_q;
  assign portNum = portNum_q;
  assign tcVcMap = tcVcMap_q;
  assign loadDone = done_q;

  // Checks
  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence fetchPending;
    imgRd_q && !imgValid;
  endsequence

  sequence fetchHeld;
    imgRd_q && $stable(imgAddr_q);
  endsequence

  // R1: address matches slot and holds while pending
  a_img_addr_map: assert property (imgRd_q |-> imgAddr_q == // R1
                                   port_cfg_pkg::IMG_PORT2_WORD + {5'h00, slot_q, 1'b0})
    else $error("image address does not match port slot");
  a_img_req_hold: assert property (fetchPending and !reloadReq |=> fetchHeld) // R1
    else $error("image request dropped before data");
  a_last_word_done: assert property (wordTaken && slot_q == 2'b11 && !reloadReq // R8
                                     |=> done_q && !imgRd_q)
    else $error("loader not done after last word");

  generate
    for (g = 0; g < port_cfg_pkg::NUM_PORTS; g++) begin : gChk
      // R2: slot implemented copy
      a_slot_copy: assert property (done_q |=> slotImpl_q[g] == $past(word_q[g][0])) // R2
        else $error("slot implemented field mismatch");
      // R3: connector clock copy
      a_clk_copy: assert property (done_q |=> slotClk_q[g] == $past(word_q[g][1])) // R3
        else $error("slot clock field mismatch");
      // R4: device specific init copy
      a_dsi_copy: assert property (done_q |=> dsiReq_q[g] == $past(word_q[g][2])) // R4
        else $error("device init field mismatch");
      // R5: low priority channel copy
      a_lpvc_copy: assert property (done_q |=> lpvcOne_q[g] == $past(word_q[g][3])) // R5
        else $error("low priority count mismatch");
      // R6: port number copy
      a_pnum_copy: assert property (done_q |=> portNum_q[g*3 +: 3] == $past(word_q[g][6:4])) // R6
        else $error("port number field mismatch");
      // R7: traffic class map copy
      a_tcmap_copy: assert property (done_q |=> tcVcMap_q[g*7 +: 7] == $past(word_q[g][15:9])) // R7
        else $error("tc map field mismatch");
    end
  endgenerate

  // R8: defaults until loading completes
  a_default_hold: assert property (!done_q |=> slotImpl_q == 4'h0 && portNum_q == 12'h000 // R8
                                   && tcVcMap_q == 28'h0000000 && dsiReq_q == 4'h0
                                   && slotClk_q == 4'h0 && lpvcOne_q == 4'h0)
    else $error("fields applied before loading finished");

  // APB answer: ready one cycle after setup, error on unmapped
  a_apb_ready: assert property (setupPhase |=> pready_q ##1 !pready_q)
    else $error("apb ready timing wrong");
  a_apb_slverr: assert property (setupPhase && !mapped |=> pready_q && pslverr_q)
    else $error("unmapped access not flagged");
  a_apb_wr_zero: assert property (setupPhase && pwrite |=> prdata_q == 32'h00000000)
    else $error("read data not zero on write");
  a_ctrl_rd_zero: assert property (setupPhase && !pwrite && hitCtrl
                                   |=> prdata_q == 32'h00000000)
    else $error("control register read not zero");

  // R8: status shows exactly one of done and busy
  a_status_bits: assert property (setupPhase && !pwrite && hitStatus // R8
                                  |=> (prdata_q[1] ^ prdata_q[0]) && ~|prdata_q[31:2])
    else $error("status bits inconsistent");

  // Reload drops the flag, then fetches port 2 again
  sequence reloadDropped;
    !done_q && !imgRd_q;
  endsequence

  sequence firstFetch;
    imgRd_q && slot_q == 2'b00 && imgAddr_q == port_cfg_pkg::IMG_PORT2_WORD;
  endsequence

  // R1: reload restarts at port 2
  a_reload_restart: assert property (reloadReq |=> reloadDropped ##1 firstFetch) // R1
    else $error("reload did not restart at first port");

  // R1: one idle cycle between word fetches
  a_fetch_gap: assert property (wordTaken |=> !imgRd_q) // R1
    else $error("image request not dropped after word");

  // R8: loading completes only on the last word
  a_done_rise: assert property ($rose(done_q) |-> $past(wordTaken && slot_q == 2'b11)) // R8
    else $error("loading finished before last word");

  // Word store: image words and strobed software writes
  generate
    for (g = 0; g < port_cfg_pkg::NUM_PORTS; g++) begin : gStore
      // R1: fetched word lands in its port slot
      a_word_take: assert property (wordTaken && slot_q == g |=> word_q[g] == $past(imgData)) // R1
        else $error("fetched word not stored");
      // Software write merges under byte strobes
      a_word_write: assert property (wrCommit && hitWord[g] && !(wordTaken && slot_q == g)
                                     |=> word_q[g] == $past(port_cfg_pkg::mergeHalf(word_q[g],
                                         pwdata[15:0], pstrb[1:0])))
        else $error("software word write lost");
    end
  endgenerate

endmodule : port_config_word_loader

`default_nettype wire

// >>> sim/img_mem_model.sv
// Behavioural configuration image memory for the word loader
`default_nettype none

module img_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Fetch port
  input wire logic imgRd,
  input wire logic [7:0] imgAddr,
  output logic [15:0] imgData,
  output logic imgValid,
  // Image contents, port 2 lowest, and answer delay
  input wire logic [63:0] memWords,
  input wire logic [3:0] memDelay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitQ;
  logic [1:0] slot;

  // word 64h sits in slot 0
  assign slot = imgAddr[2:1] - 2'b10;

  // Answer after the delay; idle data toggles so stale values never match
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      waitQ <= 4'h0;
      imgValid <= 1'b0;
      imgData <= 16'hFFFF;
    end else if (!imgRd || imgValid) begin
      waitQ <= 4'h0;
      imgValid <= 1'b0;
      imgData <= ~imgData;
    end else if (waitQ >= memDelay) begin
      imgValid <= 1'b1;
      imgData <= memWords[slot * 16 +: 16];
    end else begin
      waitQ <= waitQ + 4'h1;
      imgData <= ~imgData;
    end
  end
endmodule : img_mem_model

`default_nettype wire

// >>> sim/tb_port_config_word_loader.sv
// Self-checking bench for the port configuration word loader
`default_nettype none

module tb_port_config_word_loader;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, imgRd, imgValid, loadDone;
  logic [7:0] imgAddr;
  logic [15:0] imgData;
  logic [3:0] slotImpl, slotClk, dsiReq, lpvcOne;
  logic [11:0] portNum;
  logic [27:0] tcVcMap;
  logic [3:0] memDelay = 4'h0;
  logic [15:0] words [4] = '{16'hB4D9, 16'h4B26, 16'hFF7F, 16'h0080};
  logic [7:0] taken [$];
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;

  always #2 clk_sys = ~clk_sys;

  port_config_word_loader u_dut (.clk_sys, .rstn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .imgRd, .imgAddr, .imgData, .imgValid,
    .slotImpl, .slotClk, .dsiReq, .lpvcOne, .portNum, .tcVcMap, .loadDone);

  img_mem_model u_mem (.clk_sys, .rstn, .imgRd, .imgAddr, .imgData, .imgValid,
    .memWords({words[3], words[2], words[1], words[0]}), .memDelay);

  // Fetch log and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (imgRd === 1'b1 && imgValid === 1'b1) taken.push_back(imgAddr);
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic checkFields(input bit loaded);
    logic [15:0] w;
    for (int p = 0; p < 4; p++) begin
      w = loaded ? words[p] : 16'h0000;
      check("slotImpl", 32'(slotImpl[p]), 32'(w[0]));
      check("slotClk", 32'(slotClk[p]), 32'(w[1]));
      check("dsiReq", 32'(dsiReq[p]), 32'(w[2]));
      check("lpvcOne", 32'(lpvcOne[p]), 32'(w[3]));
      check("portNum", 32'(portNum[p * 3 +: 3]), 32'(w[6:4]));
      check("tcVcMap", 32'(tcVcMap[p * 7 +: 7]), 32'(w[15:9]));
    end
  endtask : checkFields

  task automatic waitDone();
    int n = 0;
    while (loadDone !== 1'b1 && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    check("loadDone", 32'(loadDone), 32'h1);
    repeat (2) @(posedge clk_sys);
  endtask : waitDone

  task automatic checkOrder();
    check("fetches", taken.size(), 32'h4);
    foreach (taken[i]) check("imgAddr", taken[i], 32'h64 + 32'(2 * i));
    taken.delete();
  endtask : checkOrder

  task automatic testInitialLoad();
    repeat (3) @(posedge clk_sys);
    check("loadDone early", 32'(loadDone), 32'h0);
    checkFields(1'b0);
    waitDone();
    checkFields(1'b1);
    checkOrder();
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, (port_cfg_pkg::IDX_PORT2_WORD + 12'(2 * p)) << 2, 32'h0, 4'h0);
      check("word read", rd, {16'h0, words[p]});
    end
    apb(1'b0, port_cfg_pkg::IDX_STATUS << 2, 32'h0, 4'h0);
    check("status", rd, 32'h1);
  endtask : testInitialLoad

  task automatic testUnmapped();
    apb(1'b0, 12'hFFC, 32'h0, 4'h0);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
  endtask : testUnmapped

  task automatic testSwWrite();
    // Low byte only of the port 4 word
    apb(1'b1, port_cfg_pkg::IDX_PORT4_WORD << 2, 32'h0000_1280, 4'h1);
    words[2] <= {words[2][15:8], 8'h80};
    // High byte only of the port 5 word
    apb(1'b1, port_cfg_pkg::IDX_PORT5_WORD << 2, 32'h0000_A5C3, 4'h2);
    words[3] <= {8'hA5, words[3][7:0]};
    repeat (3) @(posedge clk_sys);
    checkFields(1'b1);
  endtask : testSwWrite

  task automatic testReload();
    foreach (words[i]) words[i] <= ~words[i];
    memDelay <= 4'h6;
    apb(1'b1, port_cfg_pkg::IDX_CTRL << 2, 32'h1, 4'h1);
    repeat (2) @(posedge clk_sys);
    check("loadDone reload", 32'(loadDone), 32'h0);
    checkFields(1'b0);
    apb(1'b0, port_cfg_pkg::IDX_STATUS << 2, 32'h0, 4'h0);
    check("status busy", rd, 32'h2);
    check("status err", 32'(err), 32'h0);
    apb(1'b0, port_cfg_pkg::IDX_CTRL << 2, 32'h0, 4'h0);
    check("ctrl read", rd, 32'h0);
    waitDone();
    checkFields(1'b1);
    checkOrder();
  endtask : testReload

  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    testInitialLoad();
    testUnmapped();
    testSwWrite();
    testReload();
    stop_test();
  end
endmodule : tb_port_config_word_loader

`default_nettype wire
